// *** rtl/debug_port_pkg.sv ***
// Constants for the one-wire debug link port register set
package debug_port_pkg;

   // ***************************************************************
   // Register offsets
   // ***************************************************************
   localparam logic [3:0] OFS_PORT_REV  = 4'h0;
   localparam logic [3:0] OFS_ERR_SIG   = 4'h1;
   localparam logic [3:0] OFS_CTRL_PRI  = 4'h2;
   localparam logic [3:0] OFS_CTRL_SEC  = 4'h3;
   localparam logic [3:0] OFS_KEY_STAT  = 4'h7;
   localparam logic [3:0] OFS_RST_REQ   = 4'h8;
   localparam logic [3:0] OFS_CLK_SEL   = 4'h9;
   localparam logic [3:0] OFS_SYS_CTRL  = 4'ha;
   localparam logic [3:0] OFS_SYS_STATE = 4'hb;
   localparam logic [3:0] OFS_MEM_CHECK = 4'hc;

   // ***************************************************************
   // Field positions and masks
   // ***************************************************************
   localparam int         IBD_BIT        = 7;
   localparam int         PAR_OFF_BIT    = 5;
   localparam int         TMO_OFF_BIT    = 4;
   localparam int         RSP_OFF_BIT    = 3;
   localparam int         NACK_OFF_BIT   = 4;
   localparam int         CONT_OFF_BIT   = 3;
   localparam int         DISABLE_BIT    = 2;
   localparam int         KEY_LSB        = 3;
   localparam int         UROW_FINAL_BIT = 1;
   localparam int         CLKREQ_BIT     = 0;
   localparam logic [7:0] CTRL_PRI_MASK  = 8'hbf;
   localparam logic [7:0] CTRL_SEC_MASK  = 8'h18;

   // ***************************************************************
   // Reset values and codes
   // ***************************************************************
   localparam logic [3:0] PORT_REV_DEFAULT = 4'h3;  // Arbitrary value
   localparam logic [1:0] CLK_SEL_RESET    = 2'h3;
   localparam logic [1:0] CLK_SEL_RSVD     = 2'h0;
   localparam logic [7:0] RESET_SIGNATURE  = 8'h59;
   localparam logic [2:0] ERR_NONE         = 3'h0;
   localparam logic [2:0] ERR_PARITY       = 3'h1;
   localparam logic [2:0] ERR_FRAME        = 3'h2;
   localparam logic [2:0] ERR_TIMEOUT      = 3'h3;
   localparam logic [2:0] ERR_START        = 3'h4;
   localparam logic [2:0] ERR_CONTENTION   = 3'h7;
   localparam logic [2:0] GUARD_OFF_CODE   = 3'h7;
   localparam logic [7:0] GUARD_MAX_CYC    = 8'h80;
   localparam logic [1:0] IBD_IDLE_CHARS   = 2'h2;
   localparam int         TIMEOUT_CYCLES   = 65536;

endpackage

// *** rtl/access_timeout.sv ***
// Access-layer response timeout watchdog
module access_timeout
   import debug_port_pkg::*;
#(
   parameter int LIMIT = TIMEOUT_CYCLES
) (
   input  wire logic clk,      // Port clock
   input  wire logic rst_b,    // Async reset, active low
   input  wire logic ce,       // Clock enable
   input  wire logic start,    // Access request issued
   input  wire logic resp,     // Access layer answered
   input  wire logic off,      // Detection disabled
   output logic      expired   // One-cycle timeout pulse
);
   localparam int CW = $clog2(LIMIT + 1);

   typedef enum logic {IDLE, WAITING} wait_e;

   wait_e         state_q;
   logic [CW-1:0] cnt_q;

   // ***************************************************************
   // Wait for answer
   // ***************************************************************
   // timeout count
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         state_q <= IDLE;
         cnt_q   <= '0;
         expired <= 1'b0;
      end else if (ce) begin
         expired <= 1'b0;
         case (state_q)
            IDLE: begin
               cnt_q <= '0;
               if (start && !off) begin
                  state_q <= WAITING;
               end
            end
            WAITING: begin
               if (resp || off) begin
                  state_q <= IDLE;
               end else if (cnt_q == CW'(LIMIT - 1)) begin
                  state_q <= IDLE;
                  expired <= 1'b1;
               end else begin
                  cnt_q <= cnt_q + 1'b1;
               end
            end
            default: state_q <= IDLE;
         endcase
      end
   end

   tmo_limit_a: assert property (@(posedge clk) disable iff (!rst_b)
      $rose(expired) |-> $past(cnt_q) == CW'(LIMIT - 1))
      else $error("timeout fired at wrong count");
endmodule

// *** rtl/debug_link_port.sv ***
// Register set and control of the one-wire debug link port
// Functional notes
// - Registers reachable only from debug link instructions, never by the CPU.
// - Offsets 0x0-0x3 physical configuration, 0x4-0xC access-layer registers.
// - Bits 7:4 of first status register report read-only port revision.
// - Error signature bits 2:0 set on port error, cleared by debugger read.
// - Codes: 0 none, 1 parity, 2 stop, 4 start, 7 contention.
// - Code 3 when access layer gives no data or response.
// - Inter-byte delay bit adds two idle characters between loaded bytes.
// - First transmitted byte gets only the normal guard time.
// - Parity-off bit ignores received parity, no parity checks.
// - Timeout after 65536 cycles without answer; control bit 4 disables it.
// - Response-off bit suppresses response signatures; host uses it carefully.
// - Guard code 0-6 selects 128 down to 2 cycles; 7 none.
// - Negative-ack-off bit suppresses signature when system reset hits a transfer.
// - Contention detection active while secondary control bit 3 is zero.
// - Disable bit shuts link, lowers clock request, resets config and keys.
// - Key status bit 5 shows user-row-write key active.
// - Key status bit 4 shows programming key, clears when programming ends.
// - Key status bit 3 shows erase key, clears when erase ends.
// - Writing 0x59 asserts system reset, other values release; port unaffected.
module debug_link_port
   import debug_port_pkg::*;
#(
   parameter int         TIMEOUT_LIMIT = TIMEOUT_CYCLES,
   parameter logic [3:0] PORT_REV      = PORT_REV_DEFAULT  // Arbitrary value
) (
   input  wire logic       clk,                  // Port clock, 10 MHz
   input  wire logic       rst_b,                // Async reset, active low
   input  wire logic       ce,                   // Clock enable
   input  wire logic [3:0] reg_addr,             // Register offset from link
   input  wire logic       reg_wr,               // Store strobe
   input  wire logic       reg_rd,               // Load strobe
   input  wire logic [7:0] reg_wdata,            // Store data
   output logic      [7:0] reg_rdata,            // Load data
   input  wire logic       parity_err,           // Parity bit missampled
   input  wire logic       frame_err,            // Stop bits missampled
   input  wire logic       start_err,            // Start bit missampled
   input  wire logic       contention,           // Line drive contention seen
   input  wire logic       acc_req,              // Access issued to system
   input  wire logic       acc_resp,             // Access layer answered
   input  wire logic       op_busy,              // Load or store in progress
   input  wire logic       sys_rst_active,       // System domain in reset
   input  wire logic       sys_sleeping,         // System domain asleep
   input  wire logic       nvm_prog_ready,       // Programming may start
   input  wire logic       urow_prog_ready,      // User row programming may start
   input  wire logic       lock_state,           // Device locked
   input  wire logic [2:0] mem_check_state,      // Memory check status
   input  wire logic [2:0] key_hit,              // Key decoded: urow, prog, erase
   input  wire logic [2:0] key_done,             // Sequence finished per key
   input  wire logic       port_enable,          // Re-enable after disable
   input  wire logic       tx_byte_load,         // Next byte to transmit
   input  wire logic       tx_byte_first,        // Byte is first after turnaround
   output logic      [1:0] tx_gap_chars,         // Idle chars before byte
   output logic      [7:0] guard_cycles,         // Turnaround guard length
   output logic            inter_byte_delay_en,  // Delay between loaded bytes
   output logic            parity_check_off,     // Parity ignored
   output logic            response_sig_off,     // No response signatures
   output logic            contention_check_off, // Contention check off
   output logic            neg_ack_send,         // Send negative-ack signature
   output logic            timeout_seen,         // Access timeout pulse
   output logic            port_disabled,        // Physical link disabled
   output logic            port_reset,           // Port reset pulse
   output logic            clk_request,          // System clock request
   output logic      [1:0] clk_sel,              // Link clock select
   output logic            urow_final,           // User row write finalise
   output logic            sys_reset_req         // System reset request
);

   // ***************************************************************
   // Decode
   // ***************************************************************
   logic [7:0] ctrl_pri_q;
   logic [7:0] ctrl_sec_q;
   logic [2:0] err_sig_q;
   logic [2:0] key_q;
   logic       rstsys_q;
   logic       clkreq_q;
   logic       sysrst_prev_q;
   logic [2:0] err_code;
   logic       tmo;
   logic       acc;
   logic       wr;
   logic       rd;
   logic       dis_wr;

   assign acc    = ce && !port_disabled;
   assign wr     = acc && reg_wr;
   assign rd     = acc && reg_rd && !reg_wr;
   assign dis_wr = wr && reg_addr == OFS_CTRL_SEC && reg_wdata[DISABLE_BIT];

   assign inter_byte_delay_en  = ctrl_pri_q[IBD_BIT];
   assign parity_check_off     = ctrl_pri_q[PAR_OFF_BIT];
   assign response_sig_off     = ctrl_pri_q[RSP_OFF_BIT];
   assign contention_check_off = ctrl_sec_q[CONT_OFF_BIT];
   assign clk_request          = clkreq_q && !port_disabled;

   // ***************************************************************
   // Error signature
   // ***************************************************************
   access_timeout #(
      .LIMIT   (TIMEOUT_LIMIT)
   ) u_tmo (
      .clk     (clk),
      .rst_b   (rst_b),
      .ce      (ce && !port_disabled),
      .start   (acc_req),
      .resp    (acc_resp),
      .off     (ctrl_pri_q[TMO_OFF_BIT]),
      .expired (tmo)
   );
   assign timeout_seen = tmo;

   always_comb begin
      err_code = ERR_NONE;
      if (tmo) begin
         err_code = ERR_TIMEOUT;
      end
      if (parity_err && !parity_check_off) begin
         err_code = ERR_PARITY;
      end
      if (frame_err) begin
         err_code = ERR_FRAME;
      end
      if (start_err) begin
         err_code = ERR_START;
      end
      if (contention && !contention_check_off) begin
         err_code = ERR_CONTENTION;
      end
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         err_sig_q <= ERR_NONE;
      end else if (ce) begin
         if (dis_wr || port_disabled) begin
            err_sig_q <= ERR_NONE;
         end else if (err_code != ERR_NONE) begin
            err_sig_q <= err_code;
         end else if (rd && reg_addr == OFS_ERR_SIG) begin
            err_sig_q <= ERR_NONE;
         end
      end
   end

   // ***************************************************************
   // Physical configuration
   // ***************************************************************
   // config cleared on disable
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         ctrl_pri_q <= '0;
         ctrl_sec_q <= '0;
      end else if (ce) begin
         if (dis_wr) begin
            ctrl_pri_q <= '0;
            ctrl_sec_q <= '0;
         end else if (wr && reg_addr == OFS_CTRL_PRI) begin
            ctrl_pri_q <= reg_wdata & CTRL_PRI_MASK;
         end else if (wr && reg_addr == OFS_CTRL_SEC) begin
            ctrl_sec_q <= reg_wdata & CTRL_SEC_MASK;
         end
      end
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         port_disabled <= 1'b0;
         port_reset    <= 1'b0;
      end else if (ce) begin
         port_reset <= dis_wr;
         if (dis_wr) begin
            port_disabled <= 1'b1;
         end else if (port_enable) begin
            port_disabled <= 1'b0;
         end
      end
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         guard_cycles <= GUARD_MAX_CYC;
      end else if (ce) begin
         if (ctrl_pri_q[2:0] == GUARD_OFF_CODE) begin
            guard_cycles <= '0;
         end else begin
            guard_cycles <= GUARD_MAX_CYC >> ctrl_pri_q[2:0];
         end
      end
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         tx_gap_chars <= '0;
      end else if (ce && tx_byte_load) begin
         if (tx_byte_first || !inter_byte_delay_en) begin
            tx_gap_chars <= '0;
         end else begin
            tx_gap_chars <= IBD_IDLE_CHARS;
         end
      end
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         sysrst_prev_q <= 1'b0;
         neg_ack_send  <= 1'b0;
      end else if (ce) begin
         sysrst_prev_q <= sys_rst_active;
         neg_ack_send  <= sys_rst_active && !sysrst_prev_q && op_busy
                          && !ctrl_sec_q[NACK_OFF_BIT] && !port_disabled;
      end
   end

   // ***************************************************************
   // Keys
   // ***************************************************************
   genvar k;
   generate
      for (k = 0; k < 3; k++) begin : g_key
         always_ff @(posedge clk or negedge rst_b) begin
            if (!rst_b) begin
               key_q[k] <= 1'b0;
            end else if (ce) begin
               if (dis_wr) begin
                  key_q[k] <= 1'b0;
               end else if (key_hit[k]) begin
                  key_q[k] <= 1'b1;
               end else if (key_done[k] || (k == 2 && wr && reg_addr == OFS_KEY_STAT
                                            && reg_wdata[KEY_LSB + 2])) begin
                  key_q[k] <= 1'b0;
               end
            end
         end
      end
   endgenerate

   // ***************************************************************
   // Access-layer control
   // ***************************************************************
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         sys_reset_req <= 1'b0;
         clk_sel       <= CLK_SEL_RESET;
         clkreq_q      <= 1'b1;
         urow_final    <= 1'b0;
      end else if (ce) begin
         // reset signature, not cleared by port reset
         if (wr && reg_addr == OFS_RST_REQ) begin
            sys_reset_req <= reg_wdata == RESET_SIGNATURE;
         end
         if (dis_wr) begin
            clk_sel <= CLK_SEL_RESET;
         end else if (wr && reg_addr == OFS_CLK_SEL && reg_wdata[1:0] != CLK_SEL_RSVD) begin
            clk_sel <= reg_wdata[1:0];
         end
         if (dis_wr) begin
            clkreq_q <= 1'b0;
         end else if (port_enable && port_disabled) begin
            clkreq_q <= 1'b1;
         end else if (wr && reg_addr == OFS_SYS_CTRL) begin
            clkreq_q <= reg_wdata[CLKREQ_BIT];
         end
         if (dis_wr || !key_q[2]) begin
            urow_final <= 1'b0;
         end else if (wr && reg_addr == OFS_SYS_CTRL) begin
            urow_final <= reg_wdata[UROW_FINAL_BIT];
         end
      end
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         rstsys_q <= 1'b0;
      end else if (ce) begin
         if (sys_rst_active || sys_reset_req) begin
            rstsys_q <= 1'b1;
         end else if (rd && reg_addr == OFS_SYS_STATE) begin
            rstsys_q <= 1'b0;
         end
      end
   end

   // ***************************************************************
   // Read data
   // ***************************************************************
   // offset map
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         reg_rdata <= '0;
      end else if (rd) begin
         case (reg_addr)
            OFS_PORT_REV:  reg_rdata <= {PORT_REV, 4'h0};
            OFS_ERR_SIG:   reg_rdata <= {5'h00, err_sig_q};
            OFS_CTRL_PRI:  reg_rdata <= ctrl_pri_q;
            OFS_CTRL_SEC:  reg_rdata <= ctrl_sec_q;
            OFS_KEY_STAT:  reg_rdata <= {2'h0, key_q, 3'h0};
            OFS_RST_REQ:   reg_rdata <= {7'h00, sys_reset_req};
            OFS_CLK_SEL:   reg_rdata <= {6'h00, clk_sel};
            OFS_SYS_CTRL:  reg_rdata <= {6'h00, urow_final, clkreq_q};
            OFS_SYS_STATE: reg_rdata <= {2'h0, rstsys_q, sys_sleeping, nvm_prog_ready,
                                         urow_prog_ready, 1'b0, lock_state};
            OFS_MEM_CHECK: reg_rdata <= {5'h00, mem_check_state};
            default:       reg_rdata <= '0;
         endcase
      end
   end

   // ***************************************************************
   // Assertions
   // ***************************************************************
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_b);

   sig_capture_a: assert property (ce && !port_disabled && !dis_wr && err_code != ERR_NONE
      |=> err_sig_q == $past(err_code))
      else $error("error signature not captured");
   sig_clear_a: assert property (rd && reg_addr == OFS_ERR_SIG && err_code == ERR_NONE
      |=> err_sig_q == ERR_NONE && reg_rdata == {5'h00, $past(err_sig_q)})
      else $error("error signature not cleared by read");
   cont_code_a: assert property (ce && !port_disabled && !dis_wr && contention && !contention_check_off
      |=> err_sig_q == ERR_CONTENTION)
      else $error("contention code missing");
   parity_off_a: assert property (ce && err_sig_q == ERR_NONE && parity_check_off && !tmo
      && !frame_err && !start_err && !(contention && !contention_check_off)
      |=> err_sig_q == ERR_NONE)
      else $error("parity flagged while disabled");
   rev_read_a: assert property (rd && reg_addr == OFS_PORT_REV
      |=> reg_rdata == {PORT_REV, 4'h0})
      else $error("revision read wrong");
   rst_sig_a: assert property (wr && reg_addr == OFS_RST_REQ
      |=> sys_reset_req == ($past(reg_wdata) == RESET_SIGNATURE) && !port_reset)
      else $error("reset request mishandled");
   disable_a: assert property (dis_wr
      |=> port_disabled && port_reset && ctrl_pri_q == 8'h00 && key_q == 3'h0 && !clk_request)
      else $error("disable did not reset port");
   guard_off_a: assert property (ce && ctrl_pri_q[2:0] == GUARD_OFF_CODE
      |=> guard_cycles == 8'h00)
      else $error("guard not off");
   first_gap_a: assert property (ce && tx_byte_load && tx_byte_first
      |=> tx_gap_chars == 2'h0)
      else $error("first byte got inter-byte delay");
   key_done_a: assert property (ce && key_done[1] && !key_hit[1] && !dis_wr
      |=> !key_q[1])
      else $error("programming key not released");

   err_read_c:  cover property (err_sig_q != ERR_NONE ##[1:20] rd && reg_addr == OFS_ERR_SIG);
   rst_req_c:   cover property ($rose(sys_reset_req) ##[1:50] $fell(sys_reset_req));
   disable_c:   cover property (dis_wr ##[1:20] port_enable);
   neg_ack_c:   cover property (neg_ack_send);
endmodule

// *** verification/link_partner.sv ***
// Debugger-side model raising link errors and answering accesses
module link_partner (
   input  wire logic       clk,        // Port clock
   input  wire logic [3:0] inject,     // Contention, start, frame, parity
   input  wire logic       ask,        // Launch one access
   input  wire logic       answer_en,  // Access layer answers
   output logic            parity_err, // Parity event
   output logic            frame_err,  // Stop bit event
   output logic            start_err,  // Start bit event
   output logic            contention, // Drive contention event
   output logic            acc_req,    // Access launched
   output logic            acc_resp    // Access answered
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [2:0] dly_q;
   always_ff @(posedge clk) begin
      {contention, start_err, frame_err, parity_err} <= inject;
      acc_req <= ask;
      dly_q <= {dly_q[1:0], ask & answer_en};
      acc_resp <= dly_q[2];
   end
endmodule

// *** verification/debug_link_port_tb.sv ***
// Self-checking bench for the debug link port register set
module debug_link_port_tb
   import debug_port_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   logic clk, rst_b, ce, reg_wr, reg_rd, op_busy, sys_rst_active, sys_sleeping, nvm_prog_ready;
   logic urow_prog_ready, lock_state, port_enable, tx_byte_load, tx_byte_first, ask, answer_en;
   logic parity_err, frame_err, start_err, contention, acc_req, acc_resp, inter_byte_delay_en;
   logic parity_check_off, response_sig_off, contention_check_off, neg_ack_send, timeout_seen;
   logic port_disabled, port_reset, clk_request, urow_final, sys_reset_req;
   logic [1:0] tx_gap_chars, clk_sel;
   logic [2:0] mem_check_state, key_hit, key_done;
   logic [3:0] reg_addr, inject;
   logic [7:0] reg_wdata, reg_rdata, guard_cycles, hit;
   int failures, comparisons, resets;
   debug_link_port #(.TIMEOUT_LIMIT(16)) u_debug_link_port (.*);
   link_partner u_link_partner (.*);
   // Port reset pulses are too short for the tasks, so count them here
   always @(negedge clk) if (port_reset === 1'b1) resets++;
   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end
   task automatic end_sim;
      $display("Comparisons %0d failures %0d", comparisons, failures);
      if (failures == 0 && comparisons > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask
   task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
      comparisons++;
      if (g !== e) begin
         failures++;
         $display("MISMATCH %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic cyc(input int n);
      repeat (n) @(negedge clk);
   endtask
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      reg_addr = a;
      reg_wdata = d;
      reg_wr = 1'b1;
      cyc(1);
      reg_wr = 1'b0;
      cyc(1);
   endtask
   task automatic rd(input logic [3:0] a, input logic [7:0] e);
      reg_addr = a;
      reg_rd = 1'b1;
      cyc(1);
      reg_rd = 1'b0;
      cyc(1);
      chk($sformatf("reg %h", a), e, reg_rdata);
   endtask
   task automatic err(input logic [3:0] b, input logic [2:0] e);
      inject = b;
      cyc(1);
      inject = 4'h0;
      cyc(2);
      rd(OFS_ERR_SIG, {5'h0, e});
      rd(OFS_ERR_SIG, 8'h00);
   endtask
   task automatic acc(input logic ans, input logic e);
      answer_en = ans;
      ask = 1'b1;
      hit = 8'h00;
      cyc(1);
      ask = 1'b0;
      repeat (40) begin
         cyc(1);
         if (timeout_seen === 1'b1) hit = 8'h01;
      end
      chk("timeout", {7'h0, e}, hit);
      rd(OFS_ERR_SIG, e ? 8'h03 : 8'h00);
   endtask
   task automatic txb(input logic f, input logic [1:0] e);
      tx_byte_first = f;
      tx_byte_load = 1'b1;
      cyc(1);
      tx_byte_load = 1'b0;
      cyc(1);
      chk("gap", {6'h0, e}, {6'h0, tx_gap_chars});
   endtask
   task automatic nack(input logic [7:0] e);
      sys_rst_active = 1'b1;
      op_busy = 1'b1;
      hit = 8'h00;
      repeat (3) begin
         cyc(1);
         hit = hit + 8'(neg_ack_send === 1'b1);
      end
      sys_rst_active = 1'b0;
      op_busy = 1'b0;
      cyc(1);
      chk("nack", e, hit);
   endtask
   initial begin
      repeat (20000) @(posedge clk);
      failures++;
      end_sim();
   end
   // ***************************************************************
   // Main sequence
   // ***************************************************************
   initial begin
      {reg_wr, reg_rd, op_busy, sys_rst_active, sys_sleeping, nvm_prog_ready, urow_prog_ready} = 7'h0;
      {lock_state, port_enable, tx_byte_load, tx_byte_first, ask, answer_en} = 6'h0;
      {mem_check_state, key_hit, key_done, reg_addr, inject, reg_wdata} = 25'h0;
      ce = 1'b1;
      rst_b = 1'b0;
      cyc(2);
      rst_b = 1'b1;
      chk("guard", GUARD_MAX_CYC, guard_cycles);
      wr(OFS_PORT_REV, 8'h00);
      rd(OFS_PORT_REV, {PORT_REV_DEFAULT, 4'h0});
      for (int i = 4; i < 7; i++) begin
         wr(4'(i), 8'hff);
         rd(4'(i), 8'h00);
      end
      wr(OFS_CTRL_PRI, 8'hff);
      rd(OFS_CTRL_PRI, CTRL_PRI_MASK);
      chk("flags", 8'h07, {5'h0, inter_byte_delay_en, parity_check_off, response_sig_off});
      err(4'h1, ERR_NONE);
      for (int g = 0; g < 8; g++) begin
         wr(OFS_CTRL_PRI, 8'(g));
         chk("guard", (g == 7) ? 8'h00 : 8'h80 >> g, guard_cycles);
      end
      wr(OFS_CTRL_PRI, 8'h80);
      txb(1'b0, 2'h2);
      txb(1'b1, 2'h0);
      err(4'h1, ERR_PARITY);
      err(4'h2, ERR_FRAME);
      err(4'h4, ERR_START);
      err(4'h9, ERR_CONTENTION);
      wr(OFS_CTRL_PRI, 8'h00);
      txb(1'b0, 2'h0);
      acc(1'b0, 1'b1);
      acc(1'b1, 1'b0);
      wr(OFS_CTRL_PRI, 8'h10);
      acc(1'b0, 1'b0);
      nack(8'h01);
      {sys_sleeping, lock_state} = 2'h3;
      rd(OFS_SYS_STATE, 8'h31);
      rd(OFS_SYS_STATE, 8'h11);
      wr(OFS_RST_REQ, RESET_SIGNATURE);
      chk("sysrst", 8'h01, {7'h0, sys_reset_req});
      rd(OFS_RST_REQ, 8'h01);
      wr(OFS_RST_REQ, 8'h58);
      chk("sysrst", 8'h00, {7'h0, sys_reset_req});
      for (int i = 0; i < 3; i++) begin
         key_hit = 3'(1 << i);
         cyc(1);
         key_hit = 3'h0;
         rd(OFS_KEY_STAT, 8'h08 << i);
         key_done = 3'(1 << i);
         cyc(1);
         key_done = 3'h0;
         rd(OFS_KEY_STAT, 8'h00);
      end
      mem_check_state = 3'h4;
      rd(OFS_MEM_CHECK, 8'h04);
      wr(OFS_CTRL_SEC, 8'hfb);
      rd(OFS_CTRL_SEC, CTRL_SEC_MASK);
      chk("contoff", 8'h01, {7'h0, contention_check_off});
      err(4'h8, ERR_NONE);
      nack(8'h00);
      key_hit = 3'h7;
      cyc(1);
      key_hit = 3'h0;
      wr(OFS_SYS_CTRL, 8'h03);
      rd(OFS_SYS_CTRL, 8'h03);
      chk("urow", 8'h01, {7'h0, urow_final});
      wr(OFS_KEY_STAT, 8'h20);
      rd(OFS_KEY_STAT, 8'h18);
      rd(OFS_SYS_CTRL, 8'h01);
      wr(OFS_CLK_SEL, 8'h01);
      wr(OFS_CLK_SEL, 8'h00);
      rd(OFS_CLK_SEL, 8'h01);
      chk("clksel", 8'h01, {6'h0, clk_sel});
      wr(OFS_CTRL_SEC, 8'h04);
      chk("disable", 8'h02, {6'h0, port_disabled, clk_request});
      chk("preset", 8'h01, 8'(resets));
      wr(OFS_CTRL_PRI, 8'h80);
      port_enable = 1'b1;
      cyc(1);
      port_enable = 1'b0;
      cyc(1);
      rd(OFS_CTRL_PRI, 8'h00);
      rd(OFS_CTRL_SEC, 8'h00);
      rd(OFS_KEY_STAT, 8'h00);
      chk("clkreq", 8'h01, {7'h0, clk_request});
      rd(OFS_CLK_SEL, 8'h03);
      chk("clksel", 8'h03, {6'h0, clk_sel});
      ce = 1'b0;
      wr(OFS_RST_REQ, RESET_SIGNATURE);
      ce = 1'b1;
      chk("frozen", 8'h00, {7'h0, sys_reset_req});
      end_sim();
   end
endmodule
